//--- verif/test_two_level_vectored_irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_two_level_vectored_irq_ctrl;
   logic clk, rst_n, ext0_n, ext1_n, rx, tx, adc;
   logic last, interrupt_exit_op, t0f, t1f, t0c, t1c, lca, push, hib, lob;
   logic [1:0] instr_extra;
   logic interrupt_exit_op_go, t0_set, t1_set, sfr_wr;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [15:0] vec;
   int failures, compares, lat;

   // ************************
   // design, cpu model, clock
   // ************************
   tvi_irq_ctrl u_dut (.clk(clk), .rst_n(rst_n), .ext0_irq_pin_n(ext0_n),
      .ext1_irq_pin_n(ext1_n), .timer0_overflow_flag(t0f),
      .timer1_overflow_flag(t1f), .serial_rx_done_flag(rx),
      .serial_tx_done_flag(tx), .adc_done_flag(adc), .cpu_instr_last(last),
      .cpu_interrupt_exit_op(interrupt_exit_op), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .long_call_op_active(lca),
      .pc_push(push), .long_call_op_vector(vec), .timer0_flag_clr(t0c),
      .timer1_flag_clr(t1c), .level_hi_busy(hib), .level_lo_busy(lob));
   tvi_cpu_model u_cpu (.clk(clk), .rst_n(rst_n), .instr_extra(instr_extra),
      .interrupt_exit_op_go(interrupt_exit_op_go), .t0_set(t0_set), .t1_set(t1_set),
      .timer0_flag_clr(t0c), .timer1_flag_clr(t1c), .cpu_instr_last(last),
      .cpu_interrupt_exit_op(interrupt_exit_op), .timer0_overflow_flag(t0f),
      .timer1_overflow_flag(t1f));

   // free running machine clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ************************
   // access tasks
   // ************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string msg);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got,
                  exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      sfr_addr = a;
      @(negedge clk);
      chk({8'h00, sfr_rdata}, {8'h00, e}, "read data");
   endtask

   // wait for a call, then check its two cycles and the levels after it
   task automatic wait_call(input logic [15:0] v, input logic [1:0] clr,
                            input logic [1:0] busy);
      lat = 0;
      while (lca !== 1'b1 && lat < 20) begin
         @(negedge clk);
         lat++;
      end
      chk({15'h0000, lca}, 16'h0001, "call start");
      chk(vec, v, "vector");
      chk({14'h0000, t1c, t0c}, {14'h0000, clr}, "timer clear");
      chk({15'h0000, push}, 16'h0001, "push");
      @(negedge clk);
      chk({14'h0000, lca, push}, 16'h0002, "second cycle");
      @(negedge clk);
      chk({13'h0000, lca, hib, lob}, {14'h0000, busy}, "call end");
   endtask

   // return ends in the next cycle; levels settle one edge later, before
   // any new call can show, so the following wait_call still sees it
   task automatic ret();
      interrupt_exit_op_go = 1'b1;
      @(negedge clk);
      interrupt_exit_op_go = 1'b0;
      @(negedge clk);
   endtask

   task automatic no_call(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge clk);
         seen = seen | (lca !== 1'b0);
      end
      chk({15'h0000, seen}, 16'h0000, "unexpected call");
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // the tests need under two hundred cycles; 3000 means a hang
   initial begin
      #(40 * 3000);
      failures++;
      summarize();
   end

   // ************************
   // test sequence
   // ************************
   initial begin
      {rx, tx, adc, interrupt_exit_op_go, t0_set, t1_set, sfr_wr} = 7'h00;
      {ext0_n, ext1_n} = 2'h3;
      instr_extra = 2'h0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      failures = 0;
      compares = 0;
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      rd(tvi_pkg::PRIO_ADDR, tvi_pkg::PRIO_RST);
      rd(tvi_pkg::EN_ADDR, tvi_pkg::EN_RST);
      wr(tvi_pkg::PRIO_ADDR, 8'hFF);
      rd(tvi_pkg::PRIO_ADDR, tvi_pkg::PRIO_MASK);
      wr(tvi_pkg::EN_ADDR, 8'hFF);
      rd(tvi_pkg::EN_ADDR, tvi_pkg::EN_MASK);
      rd(8'h90, 8'h00);
      wr(tvi_pkg::PRIO_ADDR, 8'h00);
      $display("registers test done");
      // four sources at once on one level come out in polling order
      t0_set = 1'b1;
      t1_set = 1'b1;
      @(negedge clk);
      {t0_set, t1_set} = 2'h0;
      rx = 1'b1;
      adc = 1'b1;
      wait_call(16'h000B, 2'b01, 2'b01);
      chk(16'(lat), 16'h0002, "latency");
      ret();
      wait_call(16'h001B, 2'b10, 2'b01);
      ret();
      wait_call(16'h0023, 2'b00, 2'b01);
      rx = 1'b0;
      ret();
      wait_call(16'h002B, 2'b00, 2'b01);
      adc = 1'b0;
      ret();
      no_call(6);
      $display("polling test done");
      // low routine blocks low, high preempts it, blocked request lost
      wr(tvi_pkg::PRIO_ADDR, 8'h20);
      t0_set = 1'b1;
      @(negedge clk);
      t0_set = 1'b0;
      wait_call(16'h000B, 2'b01, 2'b01);
      tx = 1'b1;
      no_call(6);
      adc = 1'b1;
      wait_call(16'h002B, 2'b00, 2'b11);
      chk({15'h0000, lat <= 2}, 16'h0001, "preempt");
      adc = 1'b0;
      tx = 1'b0;
      ret();
      chk({14'h0000, hib, lob}, 16'h0001, "levels");
      ret();
      chk({14'h0000, hib, lob}, 16'h0000, "levels");
      no_call(6);
      $display("priority test done");
      // global enable, lost request, write blocks one instruction
      wr(tvi_pkg::EN_ADDR, 8'h5F);
      adc = 1'b1;
      no_call(6);
      adc = 1'b0;
      wr(tvi_pkg::EN_ADDR, 8'hDF);
      no_call(4);
      adc = 1'b1;
      wr(tvi_pkg::PRIO_ADDR, 8'h20);
      wait_call(16'h002B, 2'b00, 2'b10);
      chk(16'(lat), 16'h0001, "after write");
      adc = 1'b0;
      ret();
      instr_extra = 2'h3;
      adc = 1'b1;
      wait_call(16'h002B, 2'b00, 2'b10);
      chk({15'h0000, lat >= 2 && lat <= 5}, 16'h0001, "long op");
      adc = 1'b0;
      ret();
      instr_extra = 2'h0;
      $display("blocking test done");
      // edge request held while disabled, cleared on call
      wr(tvi_pkg::EN_ADDR, 8'h5F);
      wr(tvi_pkg::TCTL_ADDR, 8'h01);
      ext0_n = 1'b0;
      repeat (2) @(negedge clk);
      ext0_n = 1'b1;
      repeat (4) @(negedge clk);
      rd(tvi_pkg::TCTL_ADDR, 8'h03);
      wr(tvi_pkg::EN_ADDR, 8'hDF);
      wait_call(16'h0003, 2'b00, 2'b01);
      rd(tvi_pkg::TCTL_ADDR, 8'h01);
      ret();
      // level request held until the call, released inside the routine
      ext1_n = 1'b0;
      wait_call(16'h0013, 2'b00, 2'b01);
      ext1_n = 1'b1;
      repeat (6) @(negedge clk);
      rd(tvi_pkg::TCTL_ADDR, 8'h01);
      ret();
      no_call(6);
      $display("external test done");
      summarize();
   end
endmodule // test_two_level_vectored_irq_ctrl
`default_nettype wire

//--- verif/tvi_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************
// cpu sequencer and timer flag sources
// ************************
module tvi_cpu_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] instr_extra,
   input wire logic interrupt_exit_op_go,
   input wire logic t0_set,
   input wire logic t1_set,
   input wire logic timer0_flag_clr,
   input wire logic timer1_flag_clr,
   output logic cpu_instr_last,
   output logic cpu_interrupt_exit_op,
   output logic timer0_overflow_flag,
   output logic timer1_overflow_flag
);
   logic [1:0] cnt_r, cnt_nxt;
   logic ret_r, ret_nxt;
   logic t0_r, t0_nxt;
   logic t1_r, t1_nxt;

   // final cycle of each instruction; a return ends in that cycle
   assign cpu_instr_last = (cnt_r == instr_extra);
   assign cpu_interrupt_exit_op = ret_r & cpu_instr_last;
   assign timer0_overflow_flag = t0_r;
   assign timer1_overflow_flag = t1_r;

   // next instruction count, pending return and timer flags
   always_comb begin
      cnt_nxt = cpu_instr_last ? 2'h0 : cnt_r + 2'h1;
      ret_nxt = (ret_r | interrupt_exit_op_go) & ~cpu_interrupt_exit_op;
      t0_nxt = (t0_r & ~timer0_flag_clr) | t0_set;
      t1_nxt = (t1_r & ~timer1_flag_clr) | t1_set;
   end

   // register the sequencer state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= 2'h0;
         ret_r <= 1'b0;
         t0_r <= 1'b0;
         t1_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ret_r <= ret_nxt;
         t0_r <= t0_nxt;
         t1_r <= t1_nxt;
      end
   end
endmodule // tvi_cpu_model
`default_nettype wire

//--- verilog/tvi_ext_detect.sv
`timescale 1ns/1ns
`default_nettype none
module tvi_ext_detect (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_n,
   output logic low_level,
   output logic fall
);

   logic s1_r, s2_r, s3_r, st_r;
   logic s1_nxt, s2_nxt, s3_nxt, st_nxt;
   logic agree;

   // three-stage sync; stable level moves once stages two and three agree
   always_comb begin
      s1_nxt = pin_n;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      agree = (s2_r == s3_r);
      st_nxt = agree ? s2_r : st_r;
      fall = agree & ~s2_r & st_r; // [R16]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         st_r <= 1'b1;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         st_r <= st_nxt;
      end
   end

   assign low_level = ~st_r; // [R16]

endmodule // tvi_ext_detect
`default_nettype wire

//--- verilog/tvi_irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tvi_irq_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ext0_irq_pin_n,
   input wire logic ext1_irq_pin_n,
   input wire logic timer0_overflow_flag,
   input wire logic timer1_overflow_flag,
   input wire logic serial_rx_done_flag,
   input wire logic serial_tx_done_flag,
   input wire logic adc_done_flag,
   input wire logic cpu_instr_last,
   input wire logic cpu_interrupt_exit_op,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic long_call_op_active,
   output logic pc_push,
   output logic [15:0] long_call_op_vector,
   output logic timer0_flag_clr,
   output logic timer1_flag_clr,
   output logic level_hi_busy,
   output logic level_lo_busy
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [7:0] ip_r, ip_nxt, ie_r, ie_nxt;
   logic it0_r, it0_nxt, it1_r, it1_nxt;
   logic e0_flag_r, e0_flag_nxt, e1_flag_r, e1_flag_nxt;
   logic [5:0] samp_r, samp_nxt, raw_req, poll_req;
   logic [7:0] rdata_r, rdata_nxt;
   logic wr_ip, wr_ie, wr_tc, rt_event;
   logic blk_r, blk_nxt;
   logic hi_r, hi_nxt, lo_r, lo_nxt;
   logic pick_any, pick_hi, lvl_block, call_start;
   logic [2:0] pick_idx;
   tvi_pkg::tvi_call_e st_r, st_nxt;
   logic [15:0] vec_r, vec_nxt;
   logic t0c_r, t0c_nxt, t1c_r, t1c_nxt;
   logic low0, fall0, low1, fall1;

   // next value of an external request flag
   function automatic logic ext_nxt(input logic flag, input logic edge_md,
         input logic fall, input logic low, input logic wr,
         input logic wbit, input logic hw_clr);
      if (edge_md) begin
         // set wins over any clear in the same cycle
         ext_nxt = fall | (wr & wbit) | (flag & ~(wr & ~wbit) & ~hw_clr);
      end else begin
         ext_nxt = low;
      end
   endfunction

   // ****************************************************************
   // external pin detectors
   // ****************************************************************
   tvi_ext_detect u_det0 (
      .clk(clk),
      .rst_n(rst_n),
      .pin_n(ext0_irq_pin_n),
      .low_level(low0),
      .fall(fall0)
   );

   tvi_ext_detect u_det1 (
      .clk(clk),
      .rst_n(rst_n),
      .pin_n(ext1_irq_pin_n),
      .low_level(low1),
      .fall(fall1)
   );

   // ****************************************************************
   // register file
   // ****************************************************************
   // write decode and storage; enable and priority writes hold off calls
   always_comb begin
      wr_ip = sfr_wr && (sfr_addr == tvi_pkg::PRIO_ADDR);
      wr_ie = sfr_wr && (sfr_addr == tvi_pkg::EN_ADDR);
      wr_tc = sfr_wr && (sfr_addr == tvi_pkg::TCTL_ADDR);
      ip_nxt = wr_ip ? (sfr_wdata & tvi_pkg::PRIO_MASK) : ip_r; // [R3]
      ie_nxt = wr_ie ? (sfr_wdata & tvi_pkg::EN_MASK) : ie_r; // [R23]
      it0_nxt = wr_tc ? sfr_wdata[tvi_pkg::TC_IT0] : it0_r;
      it1_nxt = wr_tc ? sfr_wdata[tvi_pkg::TC_IT1] : it1_r;
      case (sfr_addr)
         tvi_pkg::PRIO_ADDR: rdata_nxt = ip_r;
         tvi_pkg::EN_ADDR: rdata_nxt = ie_r;
         tvi_pkg::TCTL_ADDR: rdata_nxt = {4'h0, e1_flag_r, it1_r,
                                          e0_flag_r, it0_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ip_r <= tvi_pkg::PRIO_RST;
         ie_r <= tvi_pkg::EN_RST;
         it0_r <= tvi_pkg::TCTL_RST[tvi_pkg::TC_IT0];
         it1_r <= tvi_pkg::TCTL_RST[tvi_pkg::TC_IT1];
         rdata_r <= 8'h00;
      end else begin
         ip_r <= ip_nxt;
         ie_r <= ie_nxt;
         it0_r <= it0_nxt;
         it1_r <= it1_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign sfr_rdata = rdata_r;

   // ****************************************************************
   // request flags and sampling
   // ****************************************************************
   // edge flags latch falls; level flags follow the pin
   always_comb begin
      e0_flag_nxt = ext_nxt(e0_flag_r, it0_r, fall0, low0, wr_tc,
         sfr_wdata[tvi_pkg::TC_IE0],
         call_start && pick_idx == tvi_pkg::SRC_EXT0); // [R10] [R16] [R20]
      e1_flag_nxt = ext_nxt(e1_flag_r, it1_r, fall1, low1, wr_tc,
         sfr_wdata[tvi_pkg::TC_IE1],
         call_start && pick_idx == tvi_pkg::SRC_EXT1); // [R10] [R16] [R20]
      raw_req = {adc_done_flag, serial_rx_done_flag | serial_tx_done_flag,
                 timer1_overflow_flag, e1_flag_r, timer0_overflow_flag,
                 e0_flag_r};
      samp_nxt = raw_req; // [R4] [R8]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         e0_flag_r <= 1'b0;
         e1_flag_r <= 1'b0;
         samp_r <= 6'h00;
      end else begin
         e0_flag_r <= e0_flag_nxt;
         e1_flag_r <= e1_flag_nxt;
         samp_r <= samp_nxt;
      end
   end

   // ****************************************************************
   // polling and blocking
   // ****************************************************************
   // only last cycle's samples are polled, nothing blocked is kept
   assign poll_req = samp_r & tvi_pkg::en_vec(ie_r)
                     & {tvi_pkg::NSRC{ie_r[tvi_pkg::EN_GLOBAL]}}; // [R8] [R23]

   tvi_prio_pick u_pick (
      .req(poll_req),
      .hi(ip_r[5:0]),
      .any(pick_any),
      .idx(pick_idx),
      .is_hi(pick_hi)
   );

   // blocking: level in progress, not last cycle, return or ie/ip write
   always_comb begin
      rt_event = cpu_interrupt_exit_op | wr_ie | wr_ip;
      blk_nxt = (rt_event | blk_r) & ~cpu_instr_last; // [R7]
      lvl_block = pick_hi ? hi_r : (hi_r | lo_r); // [R5]
      call_start = (st_r == tvi_pkg::ST_IDLE) && pick_any && !lvl_block
                   && cpu_instr_last && !rt_event && !blk_r; // [R6] [R7]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blk_r <= 1'b0;
      end else begin
         blk_r <= blk_nxt;
      end
   end

   // ****************************************************************
   // in-progress levels
   // ****************************************************************
   // return clears the highest active level; plain return is not seen
   always_comb begin
      hi_nxt = (hi_r & ~cpu_interrupt_exit_op) | (call_start & pick_hi); // [R14] [R24]
      lo_nxt = (lo_r & ~(cpu_interrupt_exit_op & ~hi_r))
               | (call_start & ~pick_hi); // [R14] [R15] [R24]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hi_r <= 1'b0;
         lo_r <= 1'b0;
      end else begin
         hi_r <= hi_nxt;
         lo_r <= lo_nxt;
      end
   end

   assign level_hi_busy = hi_r;
   assign level_lo_busy = lo_r;

   // ****************************************************************
   // hardware call sequencer
   // ****************************************************************
   // two call cycles; vector and timer clears captured at the poll
   always_comb begin
      st_nxt = st_r;
      vec_nxt = vec_r;
      t0c_nxt = 1'b0;
      t1c_nxt = 1'b0;
      case (st_r)
         tvi_pkg::ST_IDLE: begin
            if (call_start) begin
               st_nxt = tvi_pkg::ST_CALL1; // [R4] [R9]
               vec_nxt = tvi_pkg::vec_of(pick_idx); // [R13]
               t0c_nxt = (pick_idx == tvi_pkg::SRC_TMR0); // [R11]
               t1c_nxt = (pick_idx == tvi_pkg::SRC_TMR1); // [R11]
            end
         end
         tvi_pkg::ST_CALL1: st_nxt = tvi_pkg::ST_CALL2; // [R21]
         tvi_pkg::ST_CALL2: st_nxt = tvi_pkg::ST_IDLE; // [R21]
         default: st_nxt = tvi_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= tvi_pkg::ST_IDLE;
         vec_r <= 16'h0000;
         t0c_r <= 1'b0;
         t1c_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         vec_r <= vec_nxt;
         t0c_r <= t0c_nxt;
         t1c_r <= t1c_nxt;
      end
   end

   // push of the program counter only; status word untouched
   assign pc_push = (st_r == tvi_pkg::ST_CALL1); // [R12]
   assign long_call_op_active = (st_r != tvi_pkg::ST_IDLE);
   assign long_call_op_vector = vec_r;
   assign timer0_flag_clr = t0c_r;
   assign timer1_flag_clr = t1c_r;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_call_two_cycles: assert property (call_start |=>
      st_r == tvi_pkg::ST_CALL1 ##1 st_r == tvi_pkg::ST_CALL2
      ##1 st_r == tvi_pkg::ST_IDLE) // [R21]
      else $error("call did not last two cycles");

   a_call_last_cycle: assert property (call_start |-> cpu_instr_last
      && ie_r[tvi_pkg::EN_GLOBAL]) // [R6]
      else $error("call outside last cycle or globally disabled");

   a_hi_no_preempt: assert property (call_start |-> !hi_r
      && (!lo_r || pick_hi)) // [R5]
      else $error("call preempted equal or higher level");

   a_vector_map: assert property (call_start |=>
      long_call_op_vector == tvi_pkg::vec_of($past(pick_idx))) // [R13]
      else $error("wrong vector");

   a_timer_clear: assert property (call_start
      && pick_idx == tvi_pkg::SRC_TMR0 |=> timer0_flag_clr
      ##1 !timer0_flag_clr) // [R11]
      else $error("timer0 flag clear missing");

   a_interrupt_exit_op_clear: assert property (cpu_interrupt_exit_op && hi_r |=> !hi_r
      && lo_r == $past(lo_r)) // [R24]
      else $error("return did not clear highest level");

   a_ret_keeps: assert property (!cpu_interrupt_exit_op && hi_r |=> hi_r) // [R15]
      else $error("level cleared without return");

   a_poll_sample: assert property (call_start |->
      samp_r[pick_idx] && samp_r == $past(raw_req)) // [R4]
      else $error("call on request not sampled last cycle");

   a_interrupt_exit_op_block: assert property (cpu_interrupt_exit_op && cpu_instr_last
      |-> !call_start) // [R7]
      else $error("call right after return");

   a_ser_kept: assert property (serial_rx_done_flag
      && call_start |-> ##1 raw_req[tvi_pkg::SRC_SER]
      || !serial_rx_done_flag) // [R10]
      else $error("serial request dropped by call");

endmodule // tvi_irq_ctrl
`default_nettype wire

//--- verilog/tvi_pkg.sv
//
// Function
// [R1] adc completion is lowest in polling; polling only breaks same-level ties
// [R2] poll order: ext0, timer0, ext1, timer1, serial, adc
// [R3] priority register: one bit per source, one is high, bits 6-7 reserved
// [R4] flags sampled every cycle, polled next cycle, then long call to vector
// [R5] no call while equal or higher level routine is in progress
// [R6] call only in the final cycle of the current instruction
// [R7] after return or enable/priority write, one more instruction runs first
// [R8] blocked requests are not remembered; each poll uses last samples
// [R9] high request before sample point vectors within two cycles
// [R10] serial and adc flags stay set; ext flag cleared only in edge mode
// [R11] vectoring to a timer clears that timer overflow flag
// [R12] the call pushes the program counter, not the status word
// [R13] vectors 0003,000b,0013,001b,0023,002b in poll order
// [R14] interrupt return ends the in-progress level, then pops the counter
// [R15] plain subroutine return leaves the in-progress level set
// [R16] trigger select 0: low pin requests; 1: high then low sets flag
// [R17] source holds a pin level at least 12 oscillator periods
// [R18] edge source holds high one cycle, then low one cycle
// [R19] level source holds low until call, releases before routine ends
// [R20] a detected falling edge sets the flag until software or hardware clears
// [R21] the call takes two cycles; three cycles at least to first instruction
// [R22] single source response above 3 and below 9 cycles
// [R23] enable register: per-source bits plus global bit that gates all
// [R24] in-progress tracked per level; return clears highest active level
//
package tvi_pkg;

   // ****************************************************************
   // register addresses and reset values
   // ****************************************************************
   localparam logic [7:0] PRIO_ADDR = 8'hB8;
   localparam logic [7:0] EN_ADDR = 8'hA8;
   localparam logic [7:0] TCTL_ADDR = 8'h88;
   localparam logic [7:0] PRIO_RST = 8'h00;
   localparam logic [7:0] EN_RST = 8'h00;
   localparam logic [7:0] TCTL_RST = 8'h00;
   localparam logic [7:0] PRIO_MASK = 8'h3F;
   localparam logic [7:0] EN_MASK = 8'hDF;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int EN_GLOBAL = 7;
   localparam int EN_ADC = 6;
   localparam int TC_IT0 = 0;
   localparam int TC_IE0 = 1;
   localparam int TC_IT1 = 2;
   localparam int TC_IE1 = 3;
   localparam int NSRC = 6;

   // ****************************************************************
   // source indices in polling order
   // ****************************************************************
   localparam logic [2:0] SRC_EXT0 = 3'h0;
   localparam logic [2:0] SRC_TMR0 = 3'h1;
   localparam logic [2:0] SRC_EXT1 = 3'h2;
   localparam logic [2:0] SRC_TMR1 = 3'h3;
   localparam logic [2:0] SRC_SER = 3'h4;
   localparam logic [2:0] SRC_ADC = 3'h5;

   // ****************************************************************
   // call sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CALL1 = 3'b010,
      ST_CALL2 = 3'b100
   } tvi_call_e;

   // vector address of a source
   function automatic logic [15:0] vec_of(input logic [2:0] src);
      case (src)
         SRC_EXT0: vec_of = 16'h0003;
         SRC_TMR0: vec_of = 16'h000B;
         SRC_EXT1: vec_of = 16'h0013;
         SRC_TMR1: vec_of = 16'h001B;
         SRC_SER: vec_of = 16'h0023;
         default: vec_of = 16'h002B;
      endcase
   endfunction

   // per-source enables in polling order
   function automatic logic [5:0] en_vec(input logic [7:0] ie);
      en_vec = {ie[EN_ADC], ie[4:0]};
   endfunction

endpackage

//--- verilog/tvi_prio_pick.sv
`timescale 1ns/1ns
`default_nettype none
module tvi_prio_pick (
   input wire logic [5:0] req,
   input wire logic [5:0] hi,
   output logic any,
   output logic [2:0] idx,
   output logic is_hi
);

   // first set bit in polling order, index 0 highest
   function automatic logic [2:0] first(input logic [5:0] v);
      first = 3'h5;
      for (int i = 5; i >= 0; i--) begin
         if (v[i]) begin
            first = 3'(i);
         end
      end
   endfunction

   logic [5:0] hreq;

   // high level beats low; fixed order only breaks ties within a level
   always_comb begin
      hreq = req & hi;
      any = |req;
      is_hi = |hreq;
      idx = is_hi ? first(hreq) : first(req); // [R1] [R2] [R3]
   end

endmodule // tvi_prio_pick
`default_nettype wire
